/* File: pkg/tag_i2c_pkg.sv */
// Constants and types shared by the tag serial slave port
package tag_i2c_pkg;

   // -------------------------------------------------------------
   // Addresses and codes
   // -------------------------------------------------------------
   localparam logic [6:0]  DEV_ADDR_RESET   = 7'h55;
   // Arbitrary code returned in place of the stored address byte
   localparam logic [7:0]  MFR_CODE         = 8'h5a;
   localparam logic [7:0]  LAST_BLOCK_SMALL = 8'h3a;
   localparam logic [7:0]  LAST_BLOCK_LARGE = 8'h7a;
   localparam logic [7:0]  SRAM_FIRST       = 8'hf8;
   localparam logic [7:0]  SRAM_LAST        = 8'hfb;
   localparam logic [7:0]  REG_BLOCK        = 8'hfe;
   localparam logic [7:0]  REG_INDEX_MAX    = 8'h07;
   localparam logic [7:0]  SESSION_RESET    = 8'h00;

   // -------------------------------------------------------------
   // Framing
   // -------------------------------------------------------------
   localparam logic [3:0]  BYTE_BITS        = 4'h8;
   localparam logic [3:0]  LAST_BYTE_IDX    = 4'hf;
   // Synchroniser reset: SCL and SDA idle high, silence low
   localparam logic [2:0]  SYNC_RESET       = 3'h3;

   typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} state_t;
   typedef enum {PH_DEV, PH_BLOCK_ADDRESS_BYTE, PH_WDATA, PH_REGIDX, PH_MASK,
                 PH_REGISTER_DATA_BYTE, PH_READ, PH_DONE} phase_t;

endpackage

/* File: pkg/mem_port_if.sv */
// Block memory port between the serial engine and the block store
`timescale 1ns/1ps
interface mem_port_if;
   logic [11:0]  rdAddr;
   logic [7:0]   rdData;
   logic         commit;
   logic [7:0]   wrBlockAddr;
   logic [127:0] wrBlock;
   logic         busy;

   modport engine (output rdAddr, output commit, output wrBlockAddr,
                   output wrBlock, input rdData, input busy);
   modport store  (input rdAddr, input commit, input wrBlockAddr,
                   input wrBlock, output rdData, output busy);
endinterface

/* File: rtl/tag_block_mem.sv */
// Block store with the stop-launched internal write cycle
`timescale 1ns/1ps
module tag_block_mem (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // Engine side
   mem_port_if.store        port
);
   import tag_i2c_pkg::*;

   logic [7:0]   mem [0:4095];
   logic [7:0]   blkLatch;
   logic [127:0] dataLatch;
   logic [3:0]   wrIdx;
   logic         busy;

   assign port.busy = busy;

   // -------------------------------------------------------------
   // Internal write cycle, one byte per clock
   // -------------------------------------------------------------
   // Commit starts write
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy      <= 1'b0;
         wrIdx     <= 4'h0;
         blkLatch  <= 8'h00;
         dataLatch <= '0;
      end else if (!busy && port.commit) begin
         busy      <= 1'b1;
         wrIdx     <= 4'h0;
         blkLatch  <= port.wrBlockAddr;
         dataLatch <= port.wrBlock;
      end else if (busy) begin
         wrIdx <= wrIdx + 4'h1;
         if (wrIdx == LAST_BYTE_IDX)
            busy <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (busy)
         mem[{blkLatch, wrIdx}] <= dataLatch[{wrIdx, 3'h0} +: 8];
   end

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------
   // Address byte hidden
   always_ff @(posedge mclk) begin
      if (reset)
         port.rdData <= 8'h00;
      else if (port.rdAddr == 12'h000)
         port.rdData <= MFR_CODE;
      else
         port.rdData <= mem[port.rdAddr];
   end

endmodule // tag_block_mem

/* File: rtl/tag_i2c_slave.sv */
// Serial two-wire slave port with block and register access
`timescale 1ns/1ps
module tag_i2c_slave #(
   parameter bit LARGE_VARIANT = 1'b0
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // Bus pins
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOeN,
   // Silence and soft reset control
   input  wire logic silenceEnableIn,
   // Contactless side controls
   output logic      demodEnable,
   output logic      nfcHold,
   output logic      nfcRxDiscard,
   // Status
   output logic      hostLockClear,
   output logic      writeBusy
);
   import tag_i2c_pkg::*;

   mem_port_if memBus ();

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [2:0] syncA;
   logic [2:0] syncB;
   logic [2:0] pinIn;

   assign pinIn = {silenceEnableIn, sdaIn, sclIn};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gSync
         always_ff @(posedge mclk) begin
            if (reset) begin
               syncA[g] <= SYNC_RESET[g];
               syncB[g] <= SYNC_RESET[g];
            end else begin
               syncA[g] <= pinIn[g];
               syncB[g] <= syncA[g];
            end
         end
      end
   endgenerate

   logic sclS;
   logic sdaS;
   logic silenceS;
   logic sclD;
   logic sdaD;

   assign sclS     = syncB[0];
   assign sdaS     = syncB[1];
   assign silenceS = syncB[2];

   always_ff @(posedge mclk) begin
      if (reset) begin
         sclD <= 1'b1;
         sdaD <= 1'b1;
      end else begin
         sclD <= sclS;
         sdaD <= sdaS;
      end
   end

   // -------------------------------------------------------------
   // Bus conditions
   // -------------------------------------------------------------
   logic startCond;
   logic stopCond;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic softReset;
   logic inTxn;
   logic memBusy;

   assign memBusy = memBus.busy;
   assign startCond = sclS & sclD & sdaD & ~sdaS;
   assign stopCond  = sclS & sclD & ~sdaD & sdaS;
   assign sclRise   = sclS & ~sclD;
   assign sclFall   = ~sclS & sclD;
   assign startSeen = startCond & ~memBusy;
   assign softReset = inTxn & silenceS;

   // -------------------------------------------------------------
   // Transaction state
   // -------------------------------------------------------------
   state_t       state;
   phase_t       phase;
   logic [3:0]   bitCnt;
   logic [7:0]   shiftReg;
   logic [6:0]   deviceAddress;
   logic [7:0]   blockAddr;
   logic [3:0]   byteIdx;
   logic [2:0]   regIdx;
   logic [7:0]   regMask;
   logic [127:0] wrBuf;
   logic         blockValid;
   logic         isReg;
   logic         wrPending;
   logic         regWrite;
   logic         commit;
   logic [7:0]   sessionReg [0:7];

   logic         devMatch;
   logic         blockOk;
   logic         ackOk;
   logic [7:0]   txByte;
   logic [7:0]   lastBlock;

   assign lastBlock = LARGE_VARIANT ? LAST_BLOCK_LARGE : LAST_BLOCK_SMALL;
   assign devMatch  = (shiftReg[7:1] == deviceAddress);
   assign blockOk   = (shiftReg <= lastBlock) ||
                      (shiftReg >= SRAM_FIRST && shiftReg <= SRAM_LAST) ||
                      (shiftReg == REG_BLOCK);
   assign txByte    = isReg ? sessionReg[regIdx] : memBus.rdData;

   // Decides whether the byte just received earns an acknowledge
   always_comb begin
      case (phase)
         PH_DEV:    ackOk = devMatch && (!shiftReg[0] || blockValid);
         PH_BLOCK_ADDRESS_BYTE:   ackOk = blockOk;
         PH_WDATA:  ackOk = !wrPending;
         PH_REGIDX: ackOk = (shiftReg <= REG_INDEX_MAX);
         PH_MASK:   ackOk = 1'b1;
         PH_REGISTER_DATA_BYTE: ackOk = 1'b1;
         default:   ackOk = 1'b0;
      endcase
   end

   // -------------------------------------------------------------
   // Serial engine
   // -------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         state         <= ST_IDLE;
         phase         <= PH_DEV;
         bitCnt        <= 4'h0;
         shiftReg      <= 8'h00;
         sdaOeN        <= 1'b1;
         inTxn         <= 1'b0;
         blockValid    <= 1'b0;
         isReg         <= 1'b0;
         blockAddr     <= 8'h00;
         byteIdx       <= 4'h0;
         regIdx        <= 3'h0;
         regMask       <= 8'h00;
         wrBuf         <= '0;
         wrPending     <= 1'b0;
         hostLockClear <= 1'b0;
         commit        <= 1'b0;
         regWrite      <= 1'b0;
      end else begin
         hostLockClear <= 1'b0;
         commit        <= 1'b0;
         regWrite      <= 1'b0;
         if (startSeen && softReset) begin
            state      <= ST_IDLE;
            inTxn      <= 1'b0;
            sdaOeN     <= 1'b1;
            blockValid <= 1'b0;
            wrPending  <= 1'b0;
         end else if (startSeen) begin
            state  <= ST_RX;
            phase  <= PH_DEV;
            bitCnt <= 4'h0;
            inTxn  <= 1'b1;
            sdaOeN <= 1'b1;
         end else if (stopCond) begin
            state  <= ST_IDLE;
            inTxn  <= 1'b0;
            sdaOeN <= 1'b1;
            if (wrPending) begin
               commit    <= 1'b1;
               wrPending <= 1'b0;
            end
         end else begin
            case (state)
               ST_RX: begin
                  if (sclRise) begin
                     shiftReg <= {shiftReg[6:0], sdaS};
                     bitCnt   <= bitCnt + 4'h1;
                  end else if (sclFall && bitCnt == BYTE_BITS) begin
                     if (ackOk) begin
                        sdaOeN <= 1'b0;
                        state  <= ST_ACK;
                        case (phase)
                           PH_DEV: begin
                              phase <= shiftReg[0] ? PH_READ : PH_BLOCK_ADDRESS_BYTE;
                              byteIdx <= 4'h0;
                           end
                           PH_BLOCK_ADDRESS_BYTE: begin
                              blockAddr  <= shiftReg;
                              isReg      <= (shiftReg == REG_BLOCK);
                              blockValid <= 1'b1;
                              byteIdx    <= 4'h0;
                              phase      <= (shiftReg == REG_BLOCK) ?
                                            PH_REGIDX : PH_WDATA;
                           end
                           PH_WDATA: begin
                              wrBuf[{byteIdx, 3'h0} +: 8] <= shiftReg;
                              byteIdx <= byteIdx + 4'h1;
                              if (byteIdx == LAST_BYTE_IDX)
                                 wrPending <= 1'b1;
                           end
                           PH_REGIDX: begin
                              regIdx <= shiftReg[2:0];
                              phase  <= PH_MASK;
                           end
                           PH_MASK: begin
                              regMask <= shiftReg;
                              phase   <= PH_REGISTER_DATA_BYTE;
                           end
                           default: begin
                              regWrite <= 1'b1;
                              phase    <= PH_DONE;
                           end
                        endcase
                     end else begin
                        sdaOeN <= 1'b1;
                        state  <= ST_IDLE;
                        if (phase == PH_BLOCK_ADDRESS_BYTE)
                           blockValid <= 1'b0;
                        if (phase == PH_DEV && !devMatch)
                           hostLockClear <= 1'b1;
                     end
                  end
               end
               ST_ACK: begin
                  if (sclFall) begin
                     bitCnt <= 4'h0;
                     sdaOeN <= 1'b1;
                     state  <= ST_RX;
                     if (phase == PH_READ) begin
                        // First data bit goes out as the ninth pulse ends
                        sdaOeN   <= txByte[7];
                        shiftReg <= {txByte[6:0], 1'b0};
                        bitCnt   <= 4'h1;
                        state    <= ST_TX;
                     end
                  end
               end
               ST_TX: begin
                  if (sclFall) begin
                     if (bitCnt == BYTE_BITS) begin
                        sdaOeN <= 1'b1;
                        state  <= ST_TXACK;
                     end else begin
                        sdaOeN   <= shiftReg[7];
                        shiftReg <= {shiftReg[6:0], 1'b0};
                        bitCnt   <= bitCnt + 4'h1;
                     end
                  end
               end
               ST_TXACK: begin
                  if (sclRise) begin
                     if (sdaS || byteIdx == LAST_BYTE_IDX)
                        state <= ST_IDLE;
                     else
                        state <= ST_ACK;
                     byteIdx <= byteIdx + 4'h1;
                  end
               end
               default: begin
                  sdaOeN <= 1'b1;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // Device address and session registers
   // -------------------------------------------------------------
   // Address reset, then rewritable
   always_ff @(posedge mclk) begin
      if (reset)
         deviceAddress <= DEV_ADDR_RESET;
      else if (commit && blockAddr == 8'h00)
         // Only the serial path writes it
         deviceAddress <= wrBuf[7:1];
   end

   generate
      for (g = 0; g < 8; g++) begin : gSession
         always_ff @(posedge mclk) begin
            if (reset)
               sessionReg[g] <= SESSION_RESET;
            else if (regWrite && regIdx == 3'(g))
               sessionReg[g] <= (sessionReg[g] & ~regMask) |
                                (shiftReg & regMask);
         end
      end
   endgenerate

   // -------------------------------------------------------------
   // Contactless silence controls
   // -------------------------------------------------------------
   logic silenceD;

   always_ff @(posedge mclk) begin
      if (reset) begin
         silenceD     <= 1'b0;
         demodEnable  <= 1'b1;
         nfcHold      <= 1'b0;
         nfcRxDiscard <= 1'b0;
      end else begin
         silenceD     <= silenceS;
         demodEnable  <= ~silenceS;
         nfcHold      <= silenceS;
         nfcRxDiscard <= silenceS & ~silenceD;
      end
   end

   // -------------------------------------------------------------
   // Pin drive and block store
   // -------------------------------------------------------------
   // Open drain: the pad only ever pulls low, enable does the signalling
   always_ff @(posedge mclk) begin
      if (reset) begin
         sdaOut    <= 1'b0;
         writeBusy <= 1'b0;
      end else begin
         sdaOut    <= 1'b0;
         writeBusy <= memBusy;
      end
   end

   assign memBus.rdAddr      = {blockAddr, byteIdx};
   assign memBus.commit      = commit;
   assign memBus.wrBlockAddr = blockAddr;
   assign memBus.wrBlock     = wrBuf;

   tag_block_mem uStore (
      .mclk  (mclk),
      .reset (reset),
      .port  (memBus.store)
   );

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   logic quiet;

   assign quiet = !startSeen && !stopCond;

   start_enter_a: assert property (@(posedge mclk) disable iff (reset)
      startSeen && !softReset |=> state == ST_RX && phase == PH_DEV)
      else $error("start not taken");

   busy_blind_a: assert property (@(posedge mclk) disable iff (reset)
      memBusy && state == ST_IDLE |=> state == ST_IDLE)
      else $error("left idle during write cycle");

   stop_idle_a: assert property (@(posedge mclk) disable iff (reset)
      stopCond && !startSeen |=> state == ST_IDLE && sdaOeN)
      else $error("stop did not end transaction");

   stop_commit_a: assert property (@(posedge mclk) disable iff (reset)
      stopCond && !startSeen && wrPending
      |=> commit ##1 memBusy ##1 writeBusy[*2])
      else $error("write cycle not launched");

   soft_reset_a: assert property (@(posedge mclk) disable iff (reset)
      startSeen && softReset |=> state == ST_IDLE && !blockValid)
      else $error("soft reset not applied");

   silence_out_a: assert property (@(posedge mclk) disable iff (reset)
      $rose(silenceS) |=> nfcRxDiscard && !demodEnable ##1 !nfcRxDiscard)
      else $error("silence controls wrong");

   tx_release_a: assert property (@(posedge mclk) disable iff (reset)
      quiet && state == ST_TX && sclFall && bitCnt == BYTE_BITS
      |=> sdaOeN && state == ST_TXACK)
      else $error("line not released after eight bits");

   rise_sample_a: assert property (@(posedge mclk) disable iff (reset)
      quiet && state == ST_RX && sclRise
      |=> shiftReg[0] == $past(sdaS) && bitCnt == 4'($past(bitCnt) + 4'h1))
      else $error("bit not sampled on rise");

   dev_mismatch_a: assert property (@(posedge mclk) disable iff (reset)
      quiet && state == ST_RX && phase == PH_DEV && sclFall &&
      bitCnt == BYTE_BITS && !devMatch |=> hostLockClear && sdaOeN)
      else $error("mismatch handled wrong");

   bad_block_a: assert property (@(posedge mclk) disable iff (reset)
      quiet && state == ST_RX && phase == PH_BLOCK_ADDRESS_BYTE && sclFall &&
      bitCnt == BYTE_BITS && !blockOk |=> state == ST_IDLE && sdaOeN)
      else $error("invalid block acknowledged");

endmodule // tag_i2c_slave

/* File: verif/i2c_host_model.sv */
// Bus master model driving the tag serial slave port
`timescale 1ns/1ps
module i2c_host_model (
   // Clock
   input  wire logic mclk,
   // Bus lines
   output logic      scl,
   output logic      sdaHost,
   input  wire logic sdaBus
);
   initial begin
      scl = 1'b1;
      sdaHost = 1'b1;
   end
   // -------------------------------------------------------------
   // Bus phases
   // -------------------------------------------------------------
   // Ten mclk a phase keeps both SCL phases above the eight required
   task automatic hp;
      repeat (10) @(posedge mclk);
   endtask
   task automatic bitx(input logic b, output logic s);
      sdaHost <= b;
      hp;
      scl <= 1'b1;
      hp;
      s = sdaBus;
      scl <= 1'b0;
      hp;
   endtask
   task automatic start;
      sdaHost <= 1'b1;
      hp;
      scl <= 1'b1;
      hp;
      sdaHost <= 1'b0;
      hp;
      scl <= 1'b0;
      hp;
   endtask
   task automatic stop;
      sdaHost <= 1'b0;
      hp;
      scl <= 1'b1;
      hp;
      sdaHost <= 1'b1;
      hp;
   endtask
   task automatic wrByte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(v[i], s);
      bitx(1'b1, s);
      ack = ~s;
   endtask
   task automatic rdByte(output logic [7:0] v, input logic hAck);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
      bitx(~hAck, s);
   endtask
endmodule // i2c_host_model

/* File: verif/tb_tag_i2c_slave_block_access.sv */
// Self-checking bench for the tag serial slave port
`timescale 1ns/1ps
module tb_tag_i2c_slave_block_access;
   import tag_i2c_pkg::*;
   logic        mclk, reset, scl, sdaHost, sdaBus, silenceEnableIn;
   logic        sdaOut, sdaOeN, demodEnable, nfcHold, nfcRxDiscard;
   logic        hostLockClear, writeBusy, lockSeen, discardSeen, a;
   logic [31:0] seed;
   logic [7:0]  d, blk;
   logic [7:0]  expData [16];
   logic [7:0]  edges [9] = '{8'h3a, 8'h3b, 8'h7a, 8'hf7, 8'hf8, 8'hfb,
                               8'hfc, 8'hfe, 8'hff};
   int          fails, totalChecks;
   // 50 us at a 25 ns clock
   localparam int READ_GAP = 2000;
   // Pull-up wire: low if either party pulls it
   assign sdaBus = sdaHost & (sdaOeN | sdaOut);
   tag_i2c_slave tag_i2c_slave_i (.mclk(mclk), .reset(reset),
      .sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .silenceEnableIn(silenceEnableIn), .demodEnable(demodEnable),
      .nfcHold(nfcHold), .nfcRxDiscard(nfcRxDiscard),
      .hostLockClear(hostLockClear), .writeBusy(writeBusy));
   i2c_host_model i2c_host_model_i (.mclk(mclk), .scl(scl),
      .sdaHost(sdaHost), .sdaBus(sdaBus));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // One-cycle pulses are caught here so tasks need not poll them
   always @(posedge mclk) begin
      if (reset) begin
         lockSeen <= 1'b0;
         discardSeen <= 1'b0;
      end else begin
         if (hostLockClear === 1'b1) lockSeen <= 1'b1;
         if (nfcRxDiscard === 1'b1) discardSeen <= 1'b1;
      end
   end
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic validBlk(input logic [7:0] b);
      return b <= LAST_BLOCK_SMALL || b == REG_BLOCK
             || (b >= SRAM_FIRST && b <= SRAM_LAST);
   endfunction
   task automatic closeOut;
      if (fails == 0 && totalChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      totalChecks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic waitBusy(input logic v);
      int k;
      for (k = 0; k < 200 && writeBusy !== v; k++) @(posedge mclk);
      chk("write busy", writeBusy, v);
      if (writeBusy !== v) closeOut;
   endtask
   task automatic hdr(input logic [7:0] b, input logic expAck);
      i2c_host_model_i.start;
      i2c_host_model_i.wrByte({DEV_ADDR_RESET, 1'b0}, a);
      chk("address ack", a, 1'b1);
      i2c_host_model_i.wrByte(b, a);
      chk("block ack", a, expAck);
   endtask
   task automatic rdHdr(input logic expAck);
      // Gap before read start, no clock stretch
      repeat (READ_GAP) @(posedge mclk);
      i2c_host_model_i.start;
      i2c_host_model_i.wrByte({DEV_ADDR_RESET, 1'b1}, a);
      chk("read address ack", a, expAck);
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      closeOut;
   end
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      reset = 1'b1;
      silenceEnableIn = 1'b0;
      seed = 32'd66757;
      fails = 0;
      totalChecks = 0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("idle release", sdaOeN, 1'b1);
      chk("pad data", sdaOut, 1'b0);
      chk("demod reset", demodEnable, 1'b1);
      i2c_host_model_i.start;
      i2c_host_model_i.wrByte(8'h54, a);
      i2c_host_model_i.stop;
      chk("mismatch ack", a, 1'b0);
      chk("lock clear", lockSeen, 1'b1);
      // Block 0 keeps address 55h by writing AAh as its first byte
      for (int n = 0; n < 4; n++) begin
         seed = lfsr(seed);
         blk = (n == 0) ? 8'h00 : (n == 1) ? SRAM_FIRST + seed[1:0]
               : 8'h01 + seed[7:0] % 8'h3a;
         hdr(blk, 1'b1);
         for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            expData[i] = (n == 0 && i == 0) ? 8'haa : seed[7:0];
            i2c_host_model_i.wrByte(expData[i], a);
            chk("data ack", a, 1'b1);
         end
         i2c_host_model_i.stop;
         waitBusy(1'b1);
         waitBusy(1'b0);
         // Byte 0 of block 0 reads back as the fixed code
         if (n == 0) expData[0] = MFR_CODE;
         hdr(blk, 1'b1);
         i2c_host_model_i.stop;
         rdHdr(1'b1);
         for (int i = 0; i < 16; i++) begin
            i2c_host_model_i.rdByte(d, 1'b1);
            chk("read data", d, expData[i]);
         end
         i2c_host_model_i.stop;
      end
      for (int i = 0; i < 9; i++) begin
         hdr(edges[i], validBlk(edges[i]));
         i2c_host_model_i.stop;
      end
      rdHdr(1'b0);
      // Released line reads all ones when nothing drives it
      i2c_host_model_i.rdByte(d, 1'b0);
      i2c_host_model_i.stop;
      chk("no data after bad block", d, 8'hff);
      hdr(REG_BLOCK, 1'b1);
      i2c_host_model_i.wrByte(8'h03, a);
      i2c_host_model_i.wrByte(8'hf0, a);
      i2c_host_model_i.wrByte(8'ha5, a);
      i2c_host_model_i.stop;
      chk("register data ack", a, 1'b1);
      hdr(REG_BLOCK, 1'b1);
      i2c_host_model_i.wrByte(8'h03, a);
      i2c_host_model_i.stop;
      rdHdr(1'b1);
      i2c_host_model_i.rdByte(d, 1'b0);
      i2c_host_model_i.stop;
      chk("masked register", d, 8'ha0);
      silenceEnableIn <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("demod off", demodEnable, 1'b0);
      chk("discard pulse", discardSeen, 1'b1);
      chk("state hold", nfcHold, 1'b1);
      hdr(8'h05, 1'b1);
      rdHdr(1'b0);
      i2c_host_model_i.stop;
      // Soft reset must also have dropped the block selection
      rdHdr(1'b0);
      i2c_host_model_i.stop;
      chk("soft reset", a, 1'b0);
      silenceEnableIn <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("state release", nfcHold, 1'b0);
      closeOut;
   end
endmodule // tb_tag_i2c_slave_block_access
